//--- dv/adc_conversion_mode_control_assertions.sv
// Purpose: port-level checks of the converter mode control
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every instance of the block
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_mode_control_assertions
  import adc_mode_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_run_wr,
  input wire logic [1:0] i_conv_run_field,
  input wire logic [3:0] i_sample_rate_code,
  input wire logic       i_adc_full_powerdown_bit,
  input wire logic       i_result_rd,
  input wire logic       o_result_ready_n,
  input wire logic [3:0] o_status_rate,
  input wire logic       o_converting,
  input wire logic       o_adc_in_reset,
  input wire logic       o_sample_tick,
  input wire logic [1:0] o_status_run
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  logic go;
  logic stop;
  assign go = i_run_wr && i_conv_run_field == RUN_CONVERT;
  assign stop = i_run_wr && i_conv_run_field != RUN_CONVERT;
  a_reset_idle: assert property (disable iff (1'b0) i_sys_rst |=>
    o_status_run == RUN_RESET_VAL && o_result_ready_n && !o_converting)
    else $error("not idle after reset");
  a_start_conv: assert property (go |=> o_converting)
    else $error("convert write did not start");
  a_stop_conv: assert property (stop |=> !o_converting)
    else $error("power-down write did not stop");
  a_full_pd_reset: assert property (
    stop && i_adc_full_powerdown_bit |=> o_adc_in_reset)
    else $error("full power-down did not reset");
  a_standby_kept: assert property (
    stop && !i_adc_full_powerdown_bit |=> !o_adc_in_reset)
    else $error("standby entered reset");
  a_rate_shown: assert property (
    go |=> o_status_rate == $past(i_sample_rate_code))
    else $error("status rate not the requested code");
  a_rate_held: assert property (
    o_converting && $past(o_converting) && !$past(i_run_wr)
      |-> $stable(o_status_rate))
    else $error("rate changed during a run");
  a_read_clears: assert property (
    i_result_rd && !o_result_ready_n && !o_sample_tick
      && !$past(o_sample_tick) |=> o_result_ready_n)
    else $error("read did not raise ready");
endmodule : adc_conversion_mode_control_assertions
bind adc_conversion_mode_control adc_conversion_mode_control_assertions
  u_chk (.*);
`default_nettype wire

//--- dv/adc_conversion_mode_control_tb.sv
// Purpose: self-checking bench for converter mode control
// Assumes: 50 ns clock, inputs driven 2 ns after the rising edge
// Notes:   top rate codes keep sample intervals short
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_mode_control_tb
  import adc_mode_pkg::*;
;
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        i_run_wr = 1'b0;
  logic [1:0]  i_conv_run_field = RUN_POWERDOWN;
  logic [3:0]  i_sample_rate_code = RATE_TOP;
  logic        i_adc_full_powerdown_bit = 1'b0;
  logic        i_single_cycle_sel = 1'b0;
  logic        i_repeat_single_cycle_sel = 1'b0;
  logic [3:0]  i_input_mux_select = 4'h1;
  logic        i_skip_gain_cal = 1'b1;
  logic        i_skip_offset_cal = 1'b1;
  logic        i_result_rd = 1'b0;
  logic        src_en = 1'b0;
  logic        i_mod_valid, o_mod_ready, o_result_ready_n, o_converting;
  logic        o_adc_in_reset, o_sample_tick;
  logic [23:0] i_mod_data, o_conversion_result;
  logic [1:0]  o_status_run;
  logic [3:0]  o_status_rate;
  int          err_total = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          gap, n;
  adc_conversion_mode_control uut (.*);
  mod_source_model src (.i_clk(i_clk), .i_en(src_en), .i_ready(o_mod_ready),
    .o_valid(i_mod_valid), .o_data(i_mod_data));
  always #25 i_clk = ~i_clk;
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_total++;
      close_out();
    end
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc();
    @(posedge i_clk);
    #2;
  endtask : cyc
  task automatic run_wr(input logic [1:0] code);
    i_conv_run_field = code;
    i_run_wr = 1'b1;
    cyc();
    i_run_wr = 1'b0;
    cyc();
  endtask : run_wr
  task automatic rd();
    i_result_rd = 1'b1;
    cyc();
    i_result_rd = 1'b0;
    cyc();
  endtask : rd
  // gap: cycles waited until the tick; a hang shows up as a bad gap
  task automatic wait_tick(output int gap);
    gap = 0;
    do begin
      cyc();
      gap++;
    end while (o_sample_tick !== 1'b1 && gap < 3000);
  endtask : wait_tick
  initial begin
    repeat (4) cyc();
    i_sys_rst = 1'b0;
    chk(o_status_run, RUN_RESET_VAL);
    chk(o_result_ready_n, 1'b1);
    src_en = 1'b1;
    repeat (40) cyc();
    chk(o_mod_ready, 1'b0);
    $display("test reset and fill done");
    src_en = 1'b0;
    run_wr(RUN_CONVERT);
    chk(o_converting, 1'b1);
    n = 0;
    while (o_result_ready_n !== 1'b0 && n < 8) begin
      wait_tick(gap);
      repeat (2) cyc();
      n++;
    end
    chk(n, 5);
    chk(o_conversion_result, 24'h000005);
    chk(gap + 2, CLK_HZ / CONT_SPS[15]);
    // the word held by the stalled source follows the first 32
    repeat (28) wait_tick(gap);
    repeat (2) cyc();
    chk(o_conversion_result, 24'h000021);
    chk(o_mod_ready, 1'b1);
    wait_tick(gap);
    repeat (2) cyc();
    chk(o_conversion_result, 24'h000021);
    run_wr(RUN_POWERDOWN);
    chk(o_converting, 1'b0);
    $display("test continuous and drain done");
    i_skip_gain_cal = 1'b0;
    src_en = 1'b1;
    run_wr(RUN_CONVERT);
    wait_tick(gap);
    wait_tick(gap);
    chk(gap, CLK_HZ / CONT_SPS[14]);
    chk(o_status_rate, RATE_TOP);
    run_wr(RUN_POWERDOWN);
    i_skip_gain_cal = 1'b1;
    for (int c = 0; c < 16; c++) begin
      i_sample_rate_code = c[3:0];
      run_wr(RUN_CONVERT);
      chk(o_status_rate, c[3:0]);
      run_wr(RUN_POWERDOWN);
    end
    i_sample_rate_code = RATE_TOP;
    $display("test calibration and rate codes done");
    i_single_cycle_sel = 1'b1;
    i_repeat_single_cycle_sel = 1'b1;
    run_wr(RUN_CONVERT);
    wait_tick(gap);
    repeat (2) cyc();
    chk(o_result_ready_n, 1'b0);
    i_input_mux_select = 4'h2;
    repeat (3) cyc();
    chk(o_converting, 1'b0);
    chk(o_status_run, RUN_POWERDOWN);
    rd();
    chk(o_result_ready_n, 1'b1);
    $display("test repeat single and mux halt done");
    i_repeat_single_cycle_sel = 1'b0;
    run_wr(RUN_CONVERT);
    wait_tick(gap);
    repeat (2) cyc();
    chk(o_result_ready_n, 1'b0);
    chk(o_converting, 1'b0);
    rd();
    repeat (1100) cyc();
    chk(o_result_ready_n, 1'b1);
    $display("test single cycle done");
    i_single_cycle_sel = 1'b0;
    for (int c = 0; c < 4; c += 2) begin
      run_wr(RUN_CONVERT);
      run_wr(c[1:0]);
      chk(o_converting, 1'b0);
    end
    i_adc_full_powerdown_bit = 1'b1;
    run_wr(RUN_CONVERT);
    run_wr(RUN_POWERDOWN);
    chk(o_adc_in_reset, 1'b1);
    $display("test power-down codes done");
    close_out();
  end
endmodule : adc_conversion_mode_control_tb
`default_nettype wire

//--- dv/mod_source_model.sv
// Purpose: modulator result source for the mode control bench
// Assumes: a word is held until ready is seen high at an edge
// Notes:   words count up from 1; idle data toggles every cycle
`timescale 1ns/1ns
`default_nettype none
module mod_source_model (
  input  wire logic        i_clk,
  input  wire logic        i_en,
  input  wire logic        i_ready,
  output var  logic        o_valid = 1'b0,
  output var  logic [23:0] o_data = 24'h000000
);
  logic [23:0] next_q = 24'h000001;
  always @(posedge i_clk) begin
    if (!o_valid || i_ready) begin
      o_valid <= i_en;
      o_data  <= i_en ? next_q : ~o_data;
      if (i_en)
        next_q <= next_q + 24'h000001;
    end
  end
endmodule : mod_source_model
`default_nettype wire

//--- hdl/adc_conversion_mode_control.sv
// Purpose: run/standby, conversion mode and rate control of the converter
// Assumes: host fields arrive as synchronous level ports
// Notes:   conversion results come from the modulator side on i_mod_*
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_mode_control
  import adc_mode_pkg::*;
(
  input  wire logic                i_clk,
  input  wire logic                i_sys_rst,
  input  wire logic                i_run_wr,
  input  wire logic [1:0]          i_conv_run_field,
  input  wire logic [3:0]          i_sample_rate_code,
  input  wire logic                i_adc_full_powerdown_bit,
  input  wire logic                i_single_cycle_sel,
  input  wire logic                i_repeat_single_cycle_sel,
  input  wire logic [3:0]          i_input_mux_select,
  input  wire logic                i_skip_gain_cal,
  input  wire logic                i_skip_offset_cal,
  input  wire logic                i_mod_valid,
  output logic                     o_mod_ready,
  input  wire logic [RESULT_W-1:0] i_mod_data,
  input  wire logic                i_result_rd,
  output logic                     o_result_ready_n,
  output logic      [RESULT_W-1:0] o_conversion_result,
  output logic      [1:0]          o_status_run,
  output logic      [3:0]          o_status_rate,
  output logic                     o_converting,
  output logic                     o_adc_in_reset,
  output logic                     o_sample_tick
);
  typedef struct packed {
    conv_state_e         state;
    logic [1:0]          run;
    logic [1:0]          mode;
    logic [3:0]          rate;
    logic                cal_on;
    logic [3:0]          mux;
    logic [24:0]         tick_cnt;
    logic [2:0]          settle;
    logic                rdy_n;
    logic [RESULT_W-1:0] result;
    logic                tick;
  } ctl_s;

  ctl_s                st_q;
  ctl_s                st_d;
  logic [24:0]         interval;
  logic                f_valid;
  logic                f_ready;
  logic [RESULT_W-1:0] f_data;
  logic [1:0]          mode_now;
  logic                cal_now;
  logic                run_conv;
  logic                consume;

  // fifo absorbs modulator results; it drains only while converting
  result_fifo #(
    .WIDTH (RESULT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (i_mod_valid),
    .o_in_ready  (o_mod_ready),
    .i_in_data   (i_mod_data),
    .o_out_valid (f_valid),
    .i_out_ready (f_ready),
    .o_out_data  (f_data)
  );

  rate_interval_lut u_lut (
    .i_mode     (st_q.mode),
    .i_rate     (st_q.rate),
    .i_cal_on   (st_q.cal_on),
    .o_interval (interval)
  );

  always_comb begin
    mode_now = MODE_CONT;
    if (i_single_cycle_sel) begin
      mode_now = i_repeat_single_cycle_sel ? MODE_REPEAT_SINGLE_CYCLE_SEL
                                           : MODE_SINGLE;
    end
  end
  assign cal_now  = !(i_skip_gain_cal && i_skip_offset_cal);
  assign run_conv = (st_q.run == RUN_CONVERT);
  // a result is taken from the buffer only on a sample tick
  assign f_ready  = (st_q.state == ST_CONV) && st_q.tick;
  assign consume  = f_ready && f_valid;

  always_comb begin
    st_d      = st_q;
    st_d.tick = 1'b0;
    if (i_run_wr) begin
      st_d.run = i_conv_run_field;
    end
    if (i_result_rd && !st_q.rdy_n) begin
      st_d.rdy_n = 1'b1;
    end
    case (st_q.state)
      ST_STANDBY, ST_RESET, ST_DONE: begin
        // a stop written this cycle must count, not the old run field
        st_d.state = (i_adc_full_powerdown_bit &&
                      st_d.run != RUN_CONVERT)
                     ? ST_RESET : ST_STANDBY;
        if (st_q.state == ST_DONE && run_conv && !i_run_wr) begin
          // single conversion finished; waits for a new convert write
          st_d.state = ST_DONE;
        end
        if (i_run_wr && i_conv_run_field == RUN_CONVERT) begin
          st_d.state    = ST_CONV;
          st_d.mode     = mode_now;
          st_d.rate     = i_sample_rate_code;
          st_d.cal_on   = cal_now;
          st_d.mux      = i_input_mux_select;
          st_d.tick_cnt = '0;
          st_d.settle   = '0;
        end
      end
      ST_CONV: begin
        if (st_q.tick_cnt + 25'h1 >= interval) begin
          st_d.tick_cnt = '0;
          st_d.tick     = 1'b1;
        end else begin
          st_d.tick_cnt = st_q.tick_cnt + 25'h1;
        end
        if (consume) begin
          st_d.result = f_data;
          if (st_q.mode == MODE_CONT &&
              st_q.settle < 3'(SETTLE_SAMPLES - 1)) begin
            st_d.settle = st_q.settle + 3'h1;
          end else begin
            st_d.rdy_n = 1'b0;
          end
          if (st_q.mode == MODE_SINGLE) begin
            st_d.state = ST_DONE;
          end
        end
        if (!run_conv) begin
          st_d.state = ST_STANDBY;
        end else if (st_q.mode != MODE_SINGLE &&
                     i_input_mux_select != st_q.mux) begin
          st_d.state = ST_STANDBY;
          st_d.run   = RUN_POWERDOWN;
        end
      end
      default: st_d.state = ST_STANDBY;
    endcase
    // a stop write while converting still picks standby or reset over the mux halt
    if (i_run_wr && st_q.state == ST_CONV &&
        i_conv_run_field != RUN_CONVERT) begin
      st_d.state = (i_adc_full_powerdown_bit) ? ST_RESET : ST_STANDBY;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_q       <= '0;
      st_q.state <= ST_STANDBY;
      st_q.run   <= RUN_RESET_VAL;
      st_q.rdy_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_result_ready_n    = st_q.rdy_n;
  assign o_conversion_result = st_q.result;
  assign o_status_run        = st_q.run;
  assign o_status_rate       = st_q.rate;
  assign o_converting        = (st_q.state == ST_CONV);
  assign o_adc_in_reset      = (st_q.state == ST_RESET);
  assign o_sample_tick       = st_q.tick;
endmodule : adc_conversion_mode_control
`default_nettype wire

//--- hdl/adc_mode_pkg.sv
// Purpose: shared constants for the converter mode control block
// Assumes: 20 MHz system clock
// Notes:   rate tables are samples per second; intervals are CLK_HZ / sps
package adc_mode_pkg;
  localparam logic [1:0] RUN_POWERDOWN = 2'h1;
  localparam logic [1:0] RUN_CONVERT   = 2'h3;
  localparam logic [1:0] RUN_RESET_VAL = 2'h1;
  localparam logic [3:0] RATE_TOP      = 4'hf;
  localparam logic [3:0] RATE_CAL_STEP = 4'he;
  localparam int unsigned SETTLE_SAMPLES = 5;
  localparam int unsigned CLK_HZ        = 20000000;
  localparam int unsigned RESULT_W      = 24;
  localparam int unsigned FIFO_DEPTH    = 32;

  typedef enum logic [3:0] {
    ST_STANDBY = 4'h1,
    ST_RESET   = 4'h2,
    ST_CONV    = 4'h4,
    ST_DONE    = 4'h8
  } conv_state_e;

  typedef enum logic [1:0] {
    MODE_CONT   = 2'h0,
    MODE_SINGLE = 2'h1,
    MODE_REPEAT_SINGLE_CYCLE_SEL = 2'h2
  } conv_mode_e;

  // samples per second per rate code, continuous conversion
  localparam int unsigned CONT_SPS [16] = '{
    5, 10, 15, 30, 50, 60, 225, 450,
    900, 1800, 3600, 7200, 14400, 28800, 57600, 115200};
  // continuous single-cycle, with and without system calibration
  localparam int unsigned CSC_CAL_SPS [16] = '{
    1, 3, 5, 10, 13, 15, 50, 60,
    150, 299, 887, 1755, 2768, 5327, 9910, 17389};
  localparam int unsigned CSC_RAW_SPS [16] = '{
    1, 3, 5, 10, 13, 15, 50, 60,
    150, 299, 892, 1776, 2818, 5519, 10593, 19609};
  // single-cycle, with and without system calibration
  localparam int unsigned SC_CAL_SPS [16] = '{
    1, 3, 5, 10, 13, 15, 50, 60,
    150, 298, 886, 1752, 2759, 5297, 9804, 17067};
  localparam int unsigned SC_RAW_SPS [16] = '{
    1, 3, 5, 10, 13, 15, 50, 60,
    150, 299, 891, 1772, 2810, 5486, 10473, 19200};
endpackage : adc_mode_pkg

//--- hdl/rate_interval_lut.sv
// Purpose: maps mode, rate code and calibration state to a sample interval
// Assumes: interval counted in system clocks
// Notes:   purely combinational
`timescale 1ns/1ns
`default_nettype none
module rate_interval_lut
  import adc_mode_pkg::*;
(
  input  wire logic [1:0]  i_mode,
  input  wire logic [3:0]  i_rate,
  input  wire logic        i_cal_on,
  output logic      [24:0] o_interval
);
  int unsigned sps;
  always_comb begin
    sps = 1;
    case (i_mode)
      MODE_CONT: begin
        sps = CONT_SPS[i_rate];
        if (i_rate == RATE_TOP && i_cal_on) begin
          sps = CONT_SPS[RATE_CAL_STEP];
        end
      end
      MODE_REPEAT_SINGLE_CYCLE_SEL: sps = i_cal_on ? CSC_CAL_SPS[i_rate]
                                  : CSC_RAW_SPS[i_rate];
      MODE_SINGLE: sps = i_cal_on ? SC_CAL_SPS[i_rate]
                                  : SC_RAW_SPS[i_rate];
      default:     sps = 1;
    endcase
    // longest interval per result, rounded down; 1 sps needs 25 bits
    o_interval = 25'(CLK_HZ / sps);
  end
endmodule : rate_interval_lut
`default_nettype wire

//--- hdl/result_fifo.sv
// Purpose: result buffer with valid/ready on both sides
// Assumes: single clock, synchronous reset
// Notes:   honest full/empty from an occupancy count
`timescale 1ns/1ns
`default_nettype none
module result_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } fifo_s;
  fifo_s            st_q;
  fifo_s            st_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign o_in_ready  = (st_q.cnt != (AW+1)'(DEPTH));
  assign o_out_valid = (st_q.cnt != '0);
  assign o_out_data  = mem[st_q.rp];
  assign push = i_in_valid && o_in_ready;
  assign pop  = o_out_valid && i_out_ready;

  always_comb begin
    st_d = st_q;
    if (push) st_d.wp = st_q.wp + 1'b1;
    if (pop)  st_d.rp = st_q.rp + 1'b1;
    st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) st_q <= '0;
    else           st_q <= st_d;
    if (push) mem[st_q.wp] <= i_in_data;
  end
endmodule : result_fifo
`default_nettype wire
